// File: hdl/bus_mode_pkg.sv
package bus_mode_pkg;
  // ==========================================================
  // Register map
  localparam logic [6:0] BUS_MODES_ADDR = 7'h04;
  localparam logic [6:0] BUS_AUX_ADDR = 7'h05;

  // ==========================================================
  // Field positions
  localparam int LIN_FLASH_BIT = 7;
  localparam int LOW_SLOPE_BIT = 6;
  localparam int TX_TIMEOUT_BIT = 5;
  localparam int LIN_MODE_LSB = 3;
  localparam int CAN_SWK_BIT = 2;
  localparam int CAN_MODE_LSB = 0;
  localparam int PEAK_BIT = 5;
  localparam int SECOND_LIN_MODE_MODE_LSB = 0;

  // ==========================================================
  // Reset and forced values
  localparam logic [7:0] BUS_MODES_RST = 8'h20;
  localparam logic [7:0] BUS_AUX_RST = 8'h00;
  localparam logic [4:0] FS_MODES_LOW = 5'h09;
  localparam logic [7:0] FS_AUX = 8'h01;
  localparam logic [7:0] BUS_AUX_WMASK = 8'h23;

  // ==========================================================
  // Mode codes
  typedef enum logic [1:0] {
    XCVR_OFF = 2'b00,
    XCVR_WAKE = 2'b01,
    XCVR_RX_ONLY = 2'b10,
    XCVR_NORMAL = 2'b11
  } xcvr_mode_t;

  typedef enum logic [1:0] {
    SBC_INIT = 2'b00,
    SBC_NORMAL = 2'b01,
    SBC_STOP = 2'b10,
    SBC_SLEEP = 2'b11
  } sbc_mode_t;
endpackage

// File: hdl/reg_update_if.sv
// Carries the staged write and the low-power CAN remap into the core
interface reg_update_if;
  logic commit;
  logic [6:0] addr;
  logic [7:0] data;
  logic lp_valid;
  logic [1:0] lp_can;

  modport stager (output commit, output addr, output data);
  modport mapper (output lp_valid, output lp_can);
  modport core (input commit, input addr, input data, input lp_valid, input lp_can);
endinterface

// File: hdl/write_stager.sv
// Holds a write until chip select returns high, then commits it
module write_stager (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic chip_select_n_i,
  input wire logic wr_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] data_i,
  reg_update_if.stager upd
);
  logic cs_n_q, cs_n_d;
  logic pend_q, pend_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;

  // Capture inside the frame, release on the rising select edge
  always_comb begin
    cs_n_d = chip_select_n_i;
    pend_d = pend_q;
    addr_d = addr_q;
    data_d = data_q;
    if (wr_i && !chip_select_n_i) begin
      pend_d = 1'b1;
      addr_d = addr_i;
      data_d = data_i;
    end else if (chip_select_n_i && !cs_n_q) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_n_q <= 1'b1;
      pend_q <= 1'b0;
      addr_q <= 7'h00;
      data_q <= 8'h00;
    end else begin
      cs_n_q <= cs_n_d;
      pend_q <= pend_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  // Aborted frames never commit: only a completed frame counts
  assign upd.commit = pend_q && chip_select_n_i && !cs_n_q;
  assign upd.addr = addr_q;
  assign upd.data = data_q;
endmodule // write_stager

// File: hdl/can_lowpower_map.sv
// Works out the CAN mode bits on low-power entry
module can_lowpower_map (
  input wire logic sleep_entry_i,
  input wire logic stop_entry_i,
  input wire logic system_error_flag_i,
  input wire logic [1:0] can_mode_i,
  reg_update_if.mapper upd
);
  logic [1:0] can_next;

  // Only Sleep entry remaps; Stop keeps receive only as chosen
  always_comb begin
    can_next = can_mode_i;
    if (sleep_entry_i) begin
      if (can_mode_i == bus_mode_pkg::XCVR_NORMAL && !system_error_flag_i) begin
        can_next = bus_mode_pkg::XCVR_WAKE;
      end else if (can_mode_i == bus_mode_pkg::XCVR_RX_ONLY) begin
        can_next = bus_mode_pkg::XCVR_WAKE;
      end
    end
  end

  assign upd.lp_valid = sleep_entry_i || stop_entry_i;
  assign upd.lp_can = can_next;
endmodule // can_lowpower_map

// File: hdl/bus_mode_regs.sv
// How it works
// - Bit 7 of modes register set disables LIN slope control for fast traffic.
// - Bit 6 of modes register selects LIN low-slope mode.
// - Bit 5 of modes register enables the LIN transmit timeout.
// - LIN mode field bits 4:3, writable by software and device.
// - CAN field bits 2:0; top bit adds selective wake, 100 is off.
// - Device logic alters the selective-wake bit only on Fail-Safe entry and soft reset, both clearing it.
// - Fast and low-slope bits take effect when chip select rises.
// - Sleep entry without system error turns CAN normal into wake capable.
// - Sleep entry turns CAN receive only into wake; Stop keeps it.
// - CAN off or wake capable is untouched on low-power entry.
// - Fail-Safe entry reloads modes low bits to 01001 and aux to 01.
// - Aux bit 5 selects low or high supply peak threshold.
// - Peak bit writable in Init or Normal only; other writes silently dropped.
// - Second LIN mode field at aux bits 1:0, software and device.
// - Aux reserved bits 7:6 and 4:2 always read zero.
// - Modes register resets to 0x20; restart keeps top three bits.
// - Aux register resets to zero; restart keeps peak bit.
// - Interrupt follows wakes only, or all status when global set.
module bus_mode_regs (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic chip_select_n_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire bus_mode_pkg::sbc_mode_t sbc_mode_i,
  input wire logic soft_reset_i,
  input wire logic restart_i,
  input wire logic [1:0] restart_lin_mode_i,
  input wire logic [1:0] restart_can_mode_i,
  input wire logic [1:0] restart_second_lin_mode_i,
  input wire logic failsafe_entry_i,
  input wire logic sleep_entry_i,
  input wire logic stop_entry_i,
  input wire logic system_error_flag_i,
  input wire logic global_int_enable_i,
  input wire logic wake_event_i,
  input wire logic status_event_i,
  output logic [7:0] reg_rdata_o,
  output logic lin_flash_o,
  output logic lin_low_slope_sel_o,
  output logic lin_tx_timeout_enable_o,
  output logic [1:0] lin_mode_o,
  output logic [2:0] can_mode_o,
  output logic supply_peak_threshold_sel_o,
  output logic [1:0] second_lin_mode_o,
  output logic int_o
);
  // ==========================================================
  // Write staging and low-power remap
  reg_update_if upd ();

  // A write lands only when the frame closes, so a cut frame never half-applies
  write_stager u_stager (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .chip_select_n_i(chip_select_n_i),
    .wr_i(reg_wr_i),
    .addr_i(reg_addr_i),
    .data_i(reg_wdata_i),
    .upd(upd.stager)
  );

  // Register state, next values and the registered outputs
  logic [7:0] modes_q, modes_d;
  logic [7:0] aux_q, aux_d;
  logic [7:0] rdata_q, rdata_d;
  logic int_q, int_d;
  logic peak_writable;

  // Sleep and Stop entry remap of the CAN low bits
  can_lowpower_map u_map (
    .sleep_entry_i(sleep_entry_i),
    .stop_entry_i(stop_entry_i),
    .system_error_flag_i(system_error_flag_i),
    .can_mode_i(modes_q[1:0]),
    .upd(upd.mapper)
  );

  // ==========================================================
  // Register update
  // Peak bit accepts writes only in Init and Normal
  assign peak_writable = (sbc_mode_i == bus_mode_pkg::SBC_INIT) ||
                         (sbc_mode_i == bus_mode_pkg::SBC_NORMAL);

  // Device events take priority over a software write in the same cycle
  always_comb begin
    modes_d = modes_q;
    aux_d = aux_q;
    if (upd.commit) begin
      if (upd.addr == bus_mode_pkg::BUS_MODES_ADDR) begin
        modes_d = upd.data;
      end else if (upd.addr == bus_mode_pkg::BUS_AUX_ADDR) begin
        aux_d = upd.data & bus_mode_pkg::BUS_AUX_WMASK;
        if (!peak_writable) begin
          aux_d[bus_mode_pkg::PEAK_BIT] = aux_q[bus_mode_pkg::PEAK_BIT];
        end
      end
    end
    if (upd.lp_valid) begin
      modes_d[1:0] = upd.lp_can;
    end
    if (restart_i) begin
      modes_d = {modes_q[7:5], restart_lin_mode_i, modes_q[bus_mode_pkg::CAN_SWK_BIT],
                 restart_can_mode_i};
      aux_d = {2'b00, aux_q[bus_mode_pkg::PEAK_BIT], 3'b000, restart_second_lin_mode_i};
    end
    if (failsafe_entry_i) begin
      modes_d = {modes_q[7:5], bus_mode_pkg::FS_MODES_LOW};
      aux_d = bus_mode_pkg::FS_AUX;
    end
    if (soft_reset_i) begin
      modes_d = bus_mode_pkg::BUS_MODES_RST;
      aux_d = bus_mode_pkg::BUS_AUX_RST;
    end
  end

  // ==========================================================
  // Read data and interrupt
  // Read data is registered, so it trails the address by one cycle
  always_comb begin
    if (reg_addr_i == bus_mode_pkg::BUS_MODES_ADDR) begin
      rdata_d = modes_q;
    end else if (reg_addr_i == bus_mode_pkg::BUS_AUX_ADDR) begin
      rdata_d = aux_q;
    end else begin
      rdata_d = 8'h00;
    end
    int_d = wake_event_i || (global_int_enable_i && status_event_i);
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      modes_q <= bus_mode_pkg::BUS_MODES_RST;
      aux_q <= bus_mode_pkg::BUS_AUX_RST;
      rdata_q <= 8'h00;
      int_q <= 1'b0;
    end else begin
      modes_q <= modes_d;
      aux_q <= aux_d;
      rdata_q <= rdata_d;
      int_q <= int_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  // field outputs
  assign reg_rdata_o = rdata_q;
  assign lin_flash_o = modes_q[bus_mode_pkg::LIN_FLASH_BIT];
  assign lin_low_slope_sel_o = modes_q[bus_mode_pkg::LOW_SLOPE_BIT];
  assign lin_tx_timeout_enable_o = modes_q[bus_mode_pkg::TX_TIMEOUT_BIT];
  assign lin_mode_o = modes_q[bus_mode_pkg::LIN_MODE_LSB +: 2];
  assign can_mode_o = modes_q[bus_mode_pkg::CAN_MODE_LSB +: 3];
  assign supply_peak_threshold_sel_o = aux_q[bus_mode_pkg::PEAK_BIT];
  assign second_lin_mode_o = aux_q[bus_mode_pkg::SECOND_LIN_MODE_MODE_LSB +: 2];
  assign int_o = int_q;

  // ==========================================================
  // Assertions
  // Cycles free of reset-like events, where the plain rules apply
  logic quiet;
  assign quiet = !soft_reset_i && !restart_i && !failsafe_entry_i;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // Option bits follow the committed byte at select rise
  a_fast_bits_commit: assert property (
    (upd.commit && upd.addr == bus_mode_pkg::BUS_MODES_ADDR && quiet)
    |=> (modes_q[7:5] == $past(upd.data[7:5])))
    else $error("Fast or low-slope bits not updated at select rise");

  // Option bits never move mid-frame
  a_no_early_write: assert property (
    (!upd.commit && quiet) |=> $stable(modes_q[7:5]))
    else $error("Option bits changed without a committed write");

  // Selective wake is left to software outside soft reset and Fail-Safe entry
  a_swk_hw_keep: assert property (
    (!(upd.commit && upd.addr == bus_mode_pkg::BUS_MODES_ADDR) && !soft_reset_i
     && !failsafe_entry_i) |=> $stable(modes_q[2]))
    else $error("Selective-wake bit changed by device logic");

  // Normal CAN drops to wake capable on Sleep entry without a system error
  a_sleep_normal: assert property (
    (sleep_entry_i && !system_error_flag_i && modes_q[1:0] == 2'b11 && quiet)
    |=> (modes_q[1:0] == 2'b01))
    else $error("Normal CAN not moved to wake on Sleep entry");

  // Receive only survives Stop entry
  a_stop_rx_keep: assert property (
    (stop_entry_i && !sleep_entry_i && modes_q[1:0] == 2'b10 && !upd.commit && quiet)
    |=> (modes_q[1:0] == 2'b10))
    else $error("Receive only lost on Stop entry");

  // Off and wake capable are left alone
  a_lowpower_off_keep: assert property (
    (sleep_entry_i && !modes_q[1] && !upd.commit && quiet) |=> $stable(modes_q[1:0]))
    else $error("Off or wake CAN changed on low-power entry");

  // Fail-Safe reload keeps only the option bits
  a_failsafe_load: assert property (
    (failsafe_entry_i && !soft_reset_i)
    |=> (modes_q[4:0] == 5'h09 && aux_q == 8'h01 && modes_q[7:5] == $past(modes_q[7:5])))
    else $error("Fail-safe reload values wrong");

  // Peak bit frozen outside Init and Normal
  a_peak_stop_lock: assert property (
    (!peak_writable && !soft_reset_i && !failsafe_entry_i) |=> $stable(aux_q[5]))
    else $error("Peak threshold changed outside Init or Normal");

  // Reserved aux bits always clear
  a_aux_reserved_zero: assert property (
    (aux_q & 8'hdc) == 8'h00)
    else $error("Reserved aux bits not zero");

  // Soft reset values, then a read of aux one cycle later shows zero
  a_soft_reset_vals: assert property (
    soft_reset_i |=> (modes_q == 8'h20 && aux_q == 8'h00) ##1
      ($past(reg_addr_i) != bus_mode_pkg::BUS_AUX_ADDR || rdata_q == 8'h00))
    else $error("Soft reset values wrong");

  // Restart keeps the option and peak bits
  a_restart_keep: assert property (
    (restart_i && quiet == 1'b0 && !failsafe_entry_i && !soft_reset_i)
    |=> (aux_q[5] == $past(aux_q[5]) && modes_q[7:5] == $past(modes_q[7:5])))
    else $error("Restart lost preserved bits");

  // No interrupt without a qualifying event
  a_int_gating: assert property (
    (!wake_event_i && !(global_int_enable_i && status_event_i)) |=> !int_o)
    else $error("Interrupt raised without a qualifying event");

  // Interrupt follows any qualifying event
  a_int_raise: assert property (
    (wake_event_i || (global_int_enable_i && status_event_i)) |=> int_o)
    else $error("Interrupt missing after a qualifying event");

  // Sleep entry moves receive only to wake capable
  a_sleep_rx_wake: assert property (
    (sleep_entry_i && modes_q[1:0] == 2'b10 && quiet) |=> (modes_q[1:0] == 2'b01))
    else $error("Receive only CAN not moved to wake on Sleep entry");

  // A system error keeps a normal CAN on Sleep entry
  a_sleep_err_keep: assert property (
    (sleep_entry_i && system_error_flag_i && modes_q[1:0] == 2'b11 && quiet)
    |=> (modes_q[1:0] == 2'b11))
    else $error("Normal CAN changed on Sleep entry with system error");

  // Stop entry leaves every CAN code as it was
  a_stop_all_keep: assert property (
    (stop_entry_i && !sleep_entry_i && quiet) |=> (modes_q[1:0] == $past(modes_q[1:0])))
    else $error("CAN mode changed on Stop entry");

  // LIN field takes the written code
  a_lin_field_write: assert property (
    (upd.commit && upd.addr == bus_mode_pkg::BUS_MODES_ADDR && quiet)
    |=> (modes_q[4:3] == $past(upd.data[4:3])))
    else $error("LIN mode field not written");

  // CAN field takes all three bits unless a low-power entry overrides it
  a_can_field_write: assert property (
    (upd.commit && upd.addr == bus_mode_pkg::BUS_MODES_ADDR && quiet && !upd.lp_valid)
    |=> (modes_q[2:0] == $past(upd.data[2:0])))
    else $error("CAN mode field not written");

  // Peak bit follows a write in Init or Normal
  a_peak_write_open: assert property (
    (upd.commit && upd.addr == bus_mode_pkg::BUS_AUX_ADDR && peak_writable && quiet)
    |=> (aux_q[5] == $past(upd.data[5])))
    else $error("Peak threshold not written in Init or Normal");

  // Second LIN field takes the written code
  a_second_lin_mode_field_write: assert property (
    (upd.commit && upd.addr == bus_mode_pkg::BUS_AUX_ADDR && quiet)
    |=> (aux_q[1:0] == $past(upd.data[1:0])))
    else $error("Second LIN mode field not written");

  // Restart loads the cause-dependent transceiver modes
  a_restart_fields: assert property (
    (restart_i && !failsafe_entry_i && !soft_reset_i)
    |=> (modes_q[4:3] == $past(restart_lin_mode_i)
         && modes_q[1:0] == $past(restart_can_mode_i)
         && aux_q[1:0] == $past(restart_second_lin_mode_i)))
    else $error("Restart transceiver modes not loaded");

  // A write to aux never sets a reserved bit
  a_reserved_write: assert property (
    (upd.commit && upd.addr == bus_mode_pkg::BUS_AUX_ADDR) |=> ((aux_q & 8'hdc) == 8'h00))
    else $error("Write reached a reserved aux bit");

  // Main scenarios that the bench should reach
  c_sleep_remap: cover property (sleep_entry_i && modes_q[1:0] == 2'b11 ##1
    modes_q[1:0] == 2'b01);
  c_failsafe: cover property (failsafe_entry_i ##1 aux_q == 8'h01);
  c_peak_write: cover property (upd.commit && upd.addr == bus_mode_pkg::BUS_AUX_ADDR
    && peak_writable ##1 aux_q[5]);
  c_restart_keep: cover property (restart_i && modes_q[7:5] != 3'b000 ##1
    modes_q[7:5] != 3'b000);
  c_stop_rx: cover property (stop_entry_i && modes_q[1:0] == 2'b10 ##1
    modes_q[1:0] == 2'b10);
endmodule // bus_mode_regs

// File: tb/host_master.sv
// ==========================================
// Serial host that frames one byte per select window
module host_master (
  input wire logic mclk_i,
  output logic chip_select_n_o,
  output logic wr_o,
  output logic [6:0] addr_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_select_n_o = 1'b1;
    wr_o = 1'b0;
    addr_o = 7'h00;
    data_o = 8'h00;
  end
  // Frame ends with select high
  // Data line shows the inverse once released, so a stale byte never passes
  task automatic write(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk_i) chip_select_n_o <= 1'b0;
    @(negedge mclk_i) begin
      wr_o <= 1'b1;
      addr_o <= a;
      data_o <= d;
    end
    @(negedge mclk_i) begin
      wr_o <= 1'b0;
      data_o <= ~d;
    end
    @(negedge mclk_i) chip_select_n_o <= 1'b1;
    repeat (2) @(negedge mclk_i);
  endtask
  // Address line doubles as the read pointer
  task automatic set_addr(input logic [6:0] a);
    addr_o <= a;
  endtask
endmodule // host_master

// File: tb/bus_transceiver_mode_regs_tb.sv
module bus_transceiver_mode_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cs_n, wr, se = 1'b0, gie = 1'b0, we = 1'b0, ste = 1'b0, int_o;
  logic [6:0] addr;
  logic [7:0] wd, rdata, s = 8'h3c, x;
  logic [4:0] ev = 5'h00;
  logic [1:0] rl = 2'b00, rc = 2'b00, rl2 = 2'b00, lin_m, second_lin_mode_m;
  logic [2:0] can_m, c;
  logic fl, ls, to, pk, chk = 1'b0, chk_seen = 1'b0;
  logic [9:0] e;
  logic [9:0] exp_q[$];
  bus_mode_pkg::sbc_mode_t sbc = bus_mode_pkg::SBC_INIT;
  int n_errors = 0, compares = 0;
  always #5 mclk_i = ~mclk_i;
  host_master host_master_i (.mclk_i(mclk_i), .chip_select_n_o(cs_n), .wr_o(wr),
    .addr_o(addr), .data_o(wd));
  bus_mode_regs bus_mode_regs_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .chip_select_n_i(cs_n), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
    .sbc_mode_i(sbc), .soft_reset_i(ev[0]), .restart_i(ev[4]), .restart_lin_mode_i(rl),
    .restart_can_mode_i(rc), .restart_second_lin_mode_i(rl2), .failsafe_entry_i(ev[1]),
    .sleep_entry_i(ev[3]), .stop_entry_i(ev[2]), .system_error_flag_i(se),
    .global_int_enable_i(gie), .wake_event_i(we), .status_event_i(ste),
    .reg_rdata_o(rdata), .lin_flash_o(fl), .lin_low_slope_sel_o(ls),
    .lin_tx_timeout_enable_o(to), .lin_mode_o(lin_m), .can_mode_o(can_m),
    .supply_peak_threshold_sel_o(pk), .second_lin_mode_o(second_lin_mode_m), .int_o(int_o));
  // ==========================================
  // Checking
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cmp_rdata(input logic [7:0] ex);
    compares++;
    if (rdata !== ex) begin
      n_errors++;
      $display("MISMATCH read data expected %h seen %h", ex, rdata);
    end
  endtask
  task automatic cmp_modes(input logic [7:0] ex);
    compares++;
    if ({fl, ls, to, lin_m, can_m} !== ex) begin
      n_errors++;
      $display("MISMATCH mode outputs expected %h seen %h", ex, {fl, ls, to, lin_m, can_m});
    end
  endtask
  task automatic cmp_aux(input logic [7:0] ex);
    compares++;
    if ({2'b00, pk, 3'b000, second_lin_mode_m} !== ex) begin
      n_errors++;
      $display("MISMATCH aux outputs expected %h seen %h", ex, {2'b00, pk, 3'b000, second_lin_mode_m});
    end
  endtask
  task automatic cmp_int(input logic ex);
    compares++;
    if (int_o !== ex) begin
      n_errors++;
      $display("MISMATCH interrupt expected %b seen %b", ex, int_o);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Notes are taken on the falling edge half a cycle after the sampling edge, when outputs have settled
  always @(posedge mclk_i) chk_seen <= chk;
  always @(negedge mclk_i) begin
    if (chk_seen && exp_q.size() == 0) begin
      n_errors++;
      $display("MISMATCH note queue expected entry seen none");
    end else if (chk_seen) begin
      e = exp_q.pop_front();
      if (e[9:8] == 2'd1) cmp_int(e[0]);
      else cmp_rdata(e[7:0]);
      if (e[9:8] == 2'd2) cmp_modes(e[7:0]);
      if (e[9:8] == 2'd3) cmp_aux(e[7:0]);
    end
  end
  // ==========================================
  // Stimulus
  task automatic rd(input logic [6:0] a, input logic [7:0] v);
    @(negedge mclk_i) begin
      host_master_i.set_addr(a);
      chk <= 1'b1;
      exp_q.push_back({(a == 7'h04) ? 2'd2 : (a == 7'h05) ? 2'd3 : 2'd0, v});
    end
    @(negedge mclk_i) chk <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(negedge mclk_i) ev[k] <= 1'b1;
    @(negedge mclk_i) ev <= 5'h00;
  endtask
  task automatic irq(input logic w, input logic g, input logic t);
    @(negedge mclk_i) begin
      we <= w;
      gie <= g;
      ste <= t;
      chk <= 1'b1;
      exp_q.push_back({2'd1, 7'h00, w | (g & t)});
    end
    @(negedge mclk_i) begin
      we <= 1'b0;
      ste <= 1'b0;
      chk <= 1'b0;
    end
  endtask
  initial begin
    repeat (50000) @(posedge mclk_i);
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i) resetn_i = 1'b1;
    rd(7'h04, 8'h20);
    rd(7'h05, 8'h00);
    rd(7'h06, 8'h00);
    repeat (4) begin
      s = lfsr(s);
      host_master_i.write(7'h04, s);
      rd(7'h04, s);
    end
    sbc <= bus_mode_pkg::SBC_NORMAL;
    host_master_i.write(7'h05, 8'hff);
    rd(7'h05, 8'h23);
    sbc <= bus_mode_pkg::SBC_STOP;
    host_master_i.write(7'h05, 8'h02);
    rd(7'h05, 8'h22);
    sbc <= bus_mode_pkg::SBC_SLEEP;
    host_master_i.write(7'h05, 8'h00);
    rd(7'h05, 8'h20);
    sbc <= bus_mode_pkg::SBC_INIT;
    host_master_i.write(7'h05, 8'h01);
    rd(7'h05, 8'h01);
    // Each CAN code through Sleep, then through Stop, with a random error flag
    for (int i = 0; i < 16; i++) begin
      s = lfsr(s);
      c = i[2:0];
      se <= s[0];
      x = {s[7:3], c};
      host_master_i.write(7'h04, x);
      if (!i[3] && (c[1:0] == 2'b10 || (c[1:0] == 2'b11 && !s[0]))) x[1:0] = 2'b01;
      pulse(i[3] ? 2 : 3);
      rd(7'h04, x);
    end
    host_master_i.write(7'h04, 8'hff);
    host_master_i.write(7'h05, 8'h22);
    pulse(1);
    rd(7'h04, 8'he9);
    rd(7'h05, 8'h01);
    host_master_i.write(7'h04, 8'hc4);
    host_master_i.write(7'h05, 8'h20);
    rl <= 2'b10;
    rc <= 2'b11;
    rl2 <= 2'b11;
    pulse(4);
    rd(7'h04, 8'hd7);
    rd(7'h05, 8'h23);
    pulse(0);
    rd(7'h04, 8'h20);
    rd(7'h05, 8'h00);
    for (int i = 0; i < 8; i++) irq(i[0], i[1], i[2]);
    repeat (2) @(negedge mclk_i);
    end_of_test;
  end
endmodule // bus_transceiver_mode_regs_tb
